/* File: src/lsu_pkg.sv */
// Shared constants and types of the LIN sync timer control block.
package lsu_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB bus).
  localparam int LSU_AW = 8;
  localparam logic [7:0] LSU_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] LSU_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] LSU_OFS_TIMER = 8'h08;
  localparam logic [7:0] LSU_OFS_CMP = 8'h0c;
  localparam logic [7:0] LSU_OFS_STAT = 8'h10;
  localparam logic [7:0] LSU_OFS_MASK = 8'h14;

  // ==========================================================================
  // Field positions.
  localparam int LSU_C0_EDGE_TYPE = 7;
  localparam int LSU_C0_BSD_MODE = 6;
  localparam int LSU_C0_CMP_IE = 5;
  localparam int LSU_C0_STOP_IE = 4;
  localparam int LSU_C1_CNT_LSB = 4;
  localparam int LSU_C1_CNT_MSB = 7;
  localparam int LSU_ST_CMP = 3;
  localparam int LSU_ST_STOP = 1;

  // ==========================================================================
  // Widths and reset values.
  localparam int LSU_CNT_W = 4;
  localparam int LSU_TMR_W = 16;
  localparam int LSU_ST_W = 4;
  localparam logic [3:0] LSU_RST_CTRL0 = 4'h0;
  localparam logic [LSU_CNT_W-1:0] LSU_RST_STOP_CNT = 4'h3;
  localparam logic [LSU_TMR_W-1:0] LSU_RST_CMP = 16'hffff;
  localparam logic [LSU_ST_W-1:0] LSU_ST_IMPL = 4'ha;

  // ==========================================================================
  // Sync timer states.
  typedef enum logic {LSU_IDLE, LSU_RUN} lsu_state_t;

endpackage

/* File: src/lsu_sync_if.sv */
// Interface between the register file and the sync bit timer core.
`timescale 1ns/1ns
interface lsu_sync_if;
  import lsu_pkg::*;
  logic edge_type;
  logic bsd_mode;
  logic [LSU_CNT_W-1:0] stop_count;
  logic [LSU_TMR_W-1:0] compare;
  logic [LSU_TMR_W-1:0] timer;
  logic running;
  logic cmp_hit;
  logic stop_hit;

  modport ctrl (
    output edge_type, bsd_mode, stop_count, compare,
    input timer, running, cmp_hit, stop_hit
  );
  modport core (
    input edge_type, bsd_mode, stop_count, compare,
    output timer, running, cmp_hit, stop_hit
  );
endinterface

/* File: src/lsu_sync_core.sv */
// Sync bit timer: edge counting on the bus pin, stop and compare events.
`timescale 1ns/1ns
module lsu_sync_core
  import lsu_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus receive pin.
  input wire logic lin_rx,
  // Register side.
  lsu_sync_if.core sif
);

  // ==========================================================================
  // Pin synchroniser and edge detection.
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  lsu_state_t state_r;
  logic [LSU_CNT_W-1:0] fall_cnt_r;
  logic [LSU_CNT_W-1:0] rise_cnt_r;
  logic [LSU_TMR_W-1:0] timer_r;
  logic match_prev_r;

  wire fall = rx_prev_r & ~rx_sync_r;
  wire rise = ~rx_prev_r & rx_sync_r;
  wire run = (state_r == LSU_RUN);
  // The edge that opens the break is counted as falling edge number one.
  wire start = ~run & fall;
  wire live = run | start;
  wire [LSU_CNT_W-1:0] fall_nxt = start ? LSU_CNT_W'(1) : fall_cnt_r + LSU_CNT_W'(fall);
  wire [LSU_CNT_W-1:0] rise_nxt = start ? LSU_CNT_W'(0) : rise_cnt_r + LSU_CNT_W'(rise);
  // Bit-serial mode times single pulses, so the first rising edge ends the run.
  wire bsd_stop = run & rise;
  wire lin_stop = sif.edge_type ? (rise & (rise_nxt == sif.stop_count)) : // R01 R02
                                  (fall & (fall_nxt == sif.stop_count));
  wire stop_now = live & (sif.bsd_mode ? bsd_stop : lin_stop); // R03 R04
  wire match_now = run & (timer_r == sif.compare);
  wire at_max = &timer_r;
  wire [LSU_TMR_W-1:0] timer_nxt = start ? '0 : (at_max ? timer_r : timer_r + LSU_TMR_W'(1));

  assign sif.timer = timer_r;
  assign sif.running = run;
  assign sif.stop_hit = stop_now;
  assign sif.cmp_hit = match_now & ~match_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
      match_prev_r <= 1'b0;
    end else begin
      rx_meta_r <= lin_rx;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      match_prev_r <= match_now;
    end
  end

  // ==========================================================================
  // Run control; the timer holds its stop value until the next start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LSU_IDLE;
      fall_cnt_r <= '0;
      rise_cnt_r <= '0;
      timer_r <= '0;
    end else begin
      case (state_r)
        LSU_IDLE: begin
          if (start) begin
            state_r <= stop_now ? LSU_IDLE : LSU_RUN;
            fall_cnt_r <= fall_nxt;
            rise_cnt_r <= rise_nxt;
            timer_r <= timer_nxt;
          end
        end
        LSU_RUN: begin
          fall_cnt_r <= fall_nxt;
          rise_cnt_r <= rise_nxt;
          timer_r <= timer_nxt;
          if (stop_now) begin
            state_r <= LSU_IDLE;
          end
        end
        default: begin
          state_r <= LSU_IDLE;
        end
      endcase
    end
  end

endmodule // lsu_sync_core

/* File: src/lsu_sync_ctrl.sv */
// APB register file, interrupt logic and sync timer of the LIN sync unit.
// ============================================================================
// Overview of operation
// [R01] Stop edge type one: timer halts at programmed count of rising edges.
// [R02] Stop edge type zero: timer halts at programmed count of falling edges.
// [R03] Mode bit one selects bit-serial-device bus operation.
// [R04] Mode bit zero selects LIN operation.
// [R05] Compare enable set: timer equal to compare value raises the interrupt.
// [R06] Each compare match interrupt sets status bit three.
// [R07] Compare enable clear: no compare match interrupts.
// [R08] Software times bit-serial transmit pulse widths with compare interrupts.
// [R09] Stop interrupt enable set: a detected stop condition raises an interrupt.
// [R10] Stop interrupt enable clear: stop conditions raise no interrupt.
// [R11] Stop edge count resets to three; break start is falling edge one.
// [R12] Software switches bit-serial direction only with the bus pin released.
// [R13] All enabled sync events combine into one level interrupt request.
`timescale 1ns/1ns
module lsu_sync_ctrl
  import lsu_pkg::*;
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LSU_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Single-wire bus receive pin.
  input wire logic lin_rx,
  // Interrupt request, level, active high.
  output logic irq
);

  // ==========================================================================
  // Register storage.
  logic [3:0] ctrl0_r;
  logic [LSU_CNT_W-1:0] stop_cnt_r;
  logic [LSU_TMR_W-1:0] cmp_r;
  logic [LSU_ST_W-1:0] stat_r;
  logic [LSU_ST_W-1:0] stat_nxt;
  logic [LSU_ST_W-1:0] mask_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_mux;

  lsu_sync_if sif ();

  // ==========================================================================
  // APB decode.
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_ctrl0 = (paddr == LSU_OFS_CTRL0);
  wire hit_ctrl1 = (paddr == LSU_OFS_CTRL1);
  wire hit_timer = (paddr == LSU_OFS_TIMER);
  wire hit_cmp = (paddr == LSU_OFS_CMP);
  wire hit_stat = (paddr == LSU_OFS_STAT);
  wire hit_mask = (paddr == LSU_OFS_MASK);
  wire hit_any = hit_ctrl0 | hit_ctrl1 | hit_timer | hit_cmp | hit_stat | hit_mask;
  // The timer is read only, so a write to it is refused like an unmapped one.
  wire wr_ok = access & pwrite & hit_any & ~hit_timer;
  wire wr_ctrl0 = wr_ok & hit_ctrl0;
  wire wr_ctrl1 = wr_ok & hit_ctrl1;
  wire wr_cmp = wr_ok & hit_cmp;
  wire wr_stat = wr_ok & hit_stat;
  wire wr_mask = wr_ok & hit_mask;

  // Zero wait states: every access completes in its first access cycle.
  assign pready = access;
  assign pslverr = access & (~hit_any | (pwrite & hit_timer));
  assign prdata = prdata_r;

  // ==========================================================================
  // Control fields of control register 0; only edge type and mode reach the timer core.
  wire edge_type = ctrl0_r[LSU_C0_EDGE_TYPE - LSU_C0_STOP_IE];
  wire bsd_mode = ctrl0_r[LSU_C0_BSD_MODE - LSU_C0_STOP_IE];
  wire cmp_ie = ctrl0_r[LSU_C0_CMP_IE - LSU_C0_STOP_IE];
  wire stop_ie = ctrl0_r[LSU_C0_STOP_IE - LSU_C0_STOP_IE];

  assign sif.edge_type = edge_type; // R01 R02
  assign sif.bsd_mode = bsd_mode; // R03 R04
  assign sif.stop_count = stop_cnt_r;
  assign sif.compare = cmp_r;

  // ==========================================================================
  // Read data, captured in the setup cycle and held through the access.
  assign rdata_mux =
    hit_ctrl0 ? {24'h00_0000, ctrl0_r, 4'h0} :
    hit_ctrl1 ? {24'h00_0000, stop_cnt_r, 4'h0} :
    hit_timer ? {16'h0000, sif.timer} :
    hit_cmp ? {16'h0000, cmp_r} :
    hit_stat ? {28'h000_0000, stat_r} :
    hit_mask ? {28'h000_0000, mask_r} :
    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata_r <= rdata_mux;
    end
  end

  // ==========================================================================
  // Control and compare registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= LSU_RST_CTRL0;
      stop_cnt_r <= LSU_RST_STOP_CNT; // R11
      cmp_r <= LSU_RST_CMP;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= pwdata[LSU_C0_EDGE_TYPE:LSU_C0_STOP_IE];
      end
      if (wr_ctrl1) begin
        stop_cnt_r <= pwdata[LSU_C1_CNT_MSB:LSU_C1_CNT_LSB];
      end
      if (wr_cmp) begin
        cmp_r <= pwdata[LSU_TMR_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Sticky status: a one written clears a bit, and an event in the same cycle
  // wins, so no event is lost to a clear racing it.
  wire cmp_evt = sif.cmp_hit & cmp_ie; // R05 R07
  wire stop_evt = sif.stop_hit & stop_ie; // R09 R10
  logic [LSU_ST_W-1:0] evt_vec;
  logic [LSU_ST_W-1:0] clr_vec;

  always_comb begin
    evt_vec = '0;
    evt_vec[LSU_ST_CMP] = cmp_evt; // R06
    evt_vec[LSU_ST_STOP] = stop_evt;
    clr_vec = wr_stat ? pwdata[LSU_ST_W-1:0] : '0;
    stat_nxt = ((stat_r & ~clr_vec) | evt_vec) & LSU_ST_IMPL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= pwdata[LSU_ST_W-1:0] & LSU_ST_IMPL;
      end
    end
  end

  // One level request for every enabled and unmasked event.
  assign irq = |(stat_r & mask_r); // R13

  // ==========================================================================
  // Sync bit timer core. Its compare pulses let software time transmitted
  // bit-serial pulses; direction changes while the pin is driven low can fake
  // a stop, which software must avoid.
  lsu_sync_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .lin_rx(lin_rx),
    .sif(sif)
  );

  // ==========================================================================
  // Checks.
  a_cnt_reset_three: assert property (@(posedge pclk) disable iff (!presetn) // R11
    $rose(presetn) |-> (stop_cnt_r == LSU_RST_STOP_CNT))
    else $error("Stop edge count did not come out of reset as three.");

  a_rise_stop_count: assert property (@(posedge pclk) disable iff (!presetn) // R01
    (sif.stop_hit && !bsd_mode && edge_type) |->
      (u_core.rise && u_core.rise_nxt == stop_cnt_r) ##1 !sif.running)
    else $error("Rising edge stop did not halt the timer at the programmed count.");

  a_fall_stop_count: assert property (@(posedge pclk) disable iff (!presetn) // R02
    (sif.stop_hit && !bsd_mode && !edge_type) |->
      (u_core.fall && u_core.fall_nxt == stop_cnt_r) ##1 !sif.running ##1 $stable(sif.timer))
    else $error("Falling edge stop did not halt the timer at the programmed count.");

  a_bsd_rise_stop: assert property (@(posedge pclk) disable iff (!presetn) // R03
    (bsd_mode && sif.running && u_core.rise) |-> sif.stop_hit ##1 !sif.running)
    else $error("Bit-serial mode did not end the run on the first rising edge.");

  a_lin_no_early: assert property (@(posedge pclk) disable iff (!presetn) // R04
    (!bsd_mode && sif.running && u_core.rise && !edge_type) |-> !sif.stop_hit)
    else $error("LIN mode with falling stop type stopped on a rising edge.");

  a_cmp_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R05 R06
    (sif.cmp_hit && cmp_ie) |=> stat_r[LSU_ST_CMP] ##0 (irq == mask_r[LSU_ST_CMP] || irq))
    else $error("Compare match did not set its status flag.");

  a_cmp_gated: assert property (@(posedge pclk) disable iff (!presetn) // R07
    $rose(stat_r[LSU_ST_CMP]) |-> $past(cmp_ie) && $past(sif.timer) == $past(cmp_r))
    else $error("Compare flag rose without an enabled match.");

  a_stop_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R09
    (sif.stop_hit && stop_ie) |=> stat_r[LSU_ST_STOP])
    else $error("Enabled stop condition did not set its status flag.");

  a_stop_gated: assert property (@(posedge pclk) disable iff (!presetn) // R10
    $rose(stat_r[LSU_ST_STOP]) |-> $past(stop_ie) && $past(sif.stop_hit))
    else $error("Stop flag rose while stop interrupts were disabled.");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (stat_r[LSU_ST_CMP] && mask_r[LSU_ST_CMP]) || (stat_r[LSU_ST_STOP] && mask_r[LSU_ST_STOP])
      |-> irq)
    else $error("Unmasked status bit set but interrupt output low.");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (penable && psel) |-> pready)
    else $error("Access phase did not complete with ready.");

endmodule // lsu_sync_ctrl

/* File: testbench/lsu_bus_node.sv */
// Bus node model that drives the single-wire receive pin of the sync unit.
`timescale 1ns/1ns
module lsu_bus_node (
  // Clock.
  input wire logic pclk,
  // Bus pin, idle high through the pull-up.
  output logic lin_rx
);
  initial lin_rx = 1'b1;

  // ==========================================================================
  // Frame generator
  // Sends n low pulses of lo cycles, each followed by hi released cycles.
  // The pin returns to the pull-up level between pulses, as a real bus does.
  task automatic frame(input int lo, input int hi, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      lin_rx <= 1'b0;
      repeat (lo) @(posedge pclk);
      lin_rx <= 1'b1;
      repeat (hi - 1) @(posedge pclk);
    end
  endtask
endmodule // lsu_bus_node

/* File: testbench/tb_top.sv */
// Self-checking testbench of the LIN sync timer control block.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import lsu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [LSU_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lin_rx;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed = 32'h258d_ad68;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 pclk = ~pclk;

  lsu_sync_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lin_rx(lin_rx), .irq(irq));
  lsu_bus_node node_u (.pclk(pclk), .lin_rx(lin_rx));

  // ==========================================================================
  // Helpers
  function automatic int rnd(input int base, input int span);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return base + int'(seed % span);
  endfunction

  // Cycles from break start to the stop edge; the pin path adds the same delay to both ends.
  function automatic int stop_at(input logic [7:0] c0, input int cnt, input int lo, input int hi);
    if (c0[LSU_C0_BSD_MODE])
      return lo;
    if (c0[LSU_C0_EDGE_TYPE])
      return lo + (cnt - 1) * (lo + hi);
    return (cnt - 1) * (lo + hi);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // One frame with a given setup, then timer, status and interrupt checks.
  task automatic run(input logic [7:0] c0, input int cnt, input int n, input logic [3:0] m, input logic [3:0] st);
    int lo;
    int hi;
    int d;
    lo = rnd(20, 40);
    hi = rnd(20, 40);
    apb(1'b1, LSU_OFS_CMP, rnd(5, 10));
    apb(1'b1, LSU_OFS_MASK, {28'h0, m});
    apb(1'b1, LSU_OFS_CTRL0, {24'h0, c0});
    `CHK(err, 1'b0)
    apb(1'b1, LSU_OFS_CTRL1, cnt << LSU_C1_CNT_LSB);
    node_u.frame(lo, hi, n);
    d = stop_at(c0, cnt, lo, hi);
    apb(1'b0, LSU_OFS_TIMER, 32'h0000_0000);
    `CHK((rd >= d - 2) && (rd <= d + 2), 1'b1)
    apb(1'b0, LSU_OFS_STAT, 32'h0000_0000);
    `CHK(rd, {28'h0, st})
    `CHK(irq, |(st & m))
    apb(1'b1, LSU_OFS_MASK, 32'h0000_0000);
    // The mask write lands at the edge the task returns on, so look once it has settled.
    @(negedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, LSU_OFS_STAT, 32'h0000_000a);
    apb(1'b0, LSU_OFS_STAT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("test ctrl0=%h count=%0d done", c0, cnt);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  logic [7:0] ra [6] = '{LSU_OFS_CTRL0, LSU_OFS_CTRL1, LSU_OFS_TIMER, LSU_OFS_CMP, LSU_OFS_STAT, LSU_OFS_MASK};
  logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0030, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000, 32'h0000_0000};

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      `CHK(rd, rv[i])
    end
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, LSU_OFS_TIMER, 32'h0000_1234);
    `CHK(err, 1'b1)
    $display("test reset values done");
    run(8'h10, 3, 3, 4'h2, 4'h2);
    run(8'h80, 2, 2, 4'h2, 4'h0);
    run(8'h70, 1, 1, 4'h8, 4'ha);
    run(8'h50, 1, 1, 4'ha, 4'h2);
    run(8'h00, 3, 3, 4'ha, 4'h0);
    final_report();
  end
endmodule // tb_top
